/* File: dv/host_gpio_model.sv */
// Host GPIO driving the single program line
module host_gpio_model (
	input wire logic sys_clk,
	output logic prog_line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial prog_line = 1'b0;
	task automatic level(input logic v, input int cyc);
		@(posedge sys_clk);
		prog_line <= v;
		repeat (cyc - 1) @(posedge sys_clk);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			level(1'b0, 12);
			level(1'b1, 12);
		end
	endtask
	// First address pulse, optional short glitch, rest of address, gap, data, then idle high
	task automatic write(input int a, input int d, input bit g);
		pulses(1);
		if (g) begin
			level(1'b0, 4);
			level(1'b1, 12);
		end
		pulses(a - 1);
		level(1'b1, 60);
		pulses(d);
		level(1'b1, 220);
	endtask
endmodule

/* File: dv/led_ctl_properties.sv */
// Port-level assertions for the program-line controller
module led_ctl_properties (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic prog_line,
	input wire logic undervoltage,
	input wire logic unity_sufficient,
	input wire logic device_enabled_ff,
	input wire logic current_range_select,
	input wire logic bank_a_on,
	input wire logic bank_b_on,
	input wire logic bank_c_on,
	input wire logic [3:0] global_current_level,
	input wire logic unity_return_lock_bit,
	input wire logic [1:0] pump_mode,
	input wire logic [5:0] led_sink_outputs_oe_n_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	property p_sinks_on;
		$rose(device_enabled_ff) |=> led_sink_outputs_oe_n_ff == 6'h00;
	endproperty
	a_sinks_on: assert property (p_sinks_on) else $error("sinks idle after enable");
	property p_sinks_off;
		$fell(device_enabled_ff) |=> led_sink_outputs_oe_n_ff == 6'h3F;
	endproperty
	a_sinks_off: assert property (p_sinks_off) else $error("sinks driven when off");
	property p_step_one;
		pump_mode > $past(pump_mode) |-> pump_mode == $past(pump_mode) + 2'h1;
	endproperty
	a_step_one: assert property (p_step_one) else $error("pump skipped a ratio");
	property p_down_unity;
		pump_mode < $past(pump_mode) |-> pump_mode == 2'h0;
	endproperty
	a_down_unity: assert property (p_down_unity) else $error("pump fell to mid ratio");
	property p_lock_hold;
		$past(unity_return_lock_bit) && unity_return_lock_bit && $past(pump_mode) != 2'h0
			|-> pump_mode != 2'h0;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("locked pump returned");
	property p_return_unity;
		unity_sufficient && !unity_return_lock_bit && pump_mode != 2'h0 |=> pump_mode == 2'h0;
	endproperty
	a_return_unity: assert property (p_return_unity) else $error("pump kept high ratio");
	property p_uv_clear;
		undervoltage [*5] |-> !device_enabled_ff && led_sink_outputs_oe_n_ff == 6'h3F
			&& global_current_level == 4'h0 && !unity_return_lock_bit
			&& {current_range_select, bank_a_on, bank_b_on, bank_c_on} == 4'h0;
	endproperty
	a_uv_clear: assert property (p_uv_clear) else $error("undervoltage left state");
	property p_enable_filter;
		$rose(device_enabled_ff) |-> $past(prog_line, 10) && prog_line;
	endproperty
	a_enable_filter: assert property (p_enable_filter) else $error("enable on short high");
endmodule
bind led_prog_ctrl led_ctl_properties u_props (.sys_clk, .rst_n, .prog_line, .undervoltage,
	.unity_sufficient, .device_enabled_ff, .current_range_select, .bank_a_on, .bank_b_on,
	.bank_c_on, .global_current_level, .unity_return_lock_bit, .pump_mode,
	.led_sink_outputs_oe_n_ff);

/* File: dv/tb_led_prog_ctrl.sv */
// Self-checking bench for the program-line controller
module tb_led_prog_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic undervoltage = 1'b0;
	logic regulation_low = 1'b0;
	logic unity_sufficient = 1'b0;
	wire prog_line, device_enabled_ff, current_range_select, bank_a_on, bank_b_on, bank_c_on;
	wire unity_return_lock_bit;
	wire [3:0] global_current_level, bank_a_current_level;
	wire [3:0] bank_b_current_level, bank_c_current_level;
	wire [1:0] pump_mode;
	wire [5:0] led_sink_outputs_oe_n_ff;
	wire [3:0] bank_enable_and_range = {current_range_select, bank_a_on, bank_b_on, bank_c_on};
	int n_mismatch = 0;
	int checked = 0;
	always #10 sys_clk = ~sys_clk;
	host_gpio_model u_host (.sys_clk(sys_clk), .prog_line(prog_line));
	led_prog_ctrl #(.OFF_CYC(17'd200), .DATA_TMO_CYC(17'd150), .IDLE_CYC(17'd30),
		.PWRDN_CYC(17'd50), .QUAL_CYC(17'd40)) u_dut (.sys_clk, .rst_n, .prog_line,
		.undervoltage, .regulation_low, .unity_sufficient, .device_enabled_ff,
		.current_range_select, .bank_a_on, .bank_b_on, .bank_c_on, .global_current_level,
		.bank_a_current_level, .bank_b_current_level, .bank_c_current_level,
		.unity_return_lock_bit, .pump_mode, .led_sink_outputs_oe_n_ff);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		#1;
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Waits for a pump ratio, bounded, and checks the qualification delay
	task automatic wait_mode(input logic [1:0] m);
		int i;
		i = 0;
		while (pump_mode !== m && i < 100) begin
			@(posedge sys_clk);
			#1;
			i++;
		end
		check(pump_mode, m);
		check(i >= 35, 1'b1);
		if (i == 100)
			report_and_stop();
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		check(led_sink_outputs_oe_n_ff, 8'h3F);
		check({device_enabled_ff, pump_mode}, 8'h00);
		u_host.level(1'b1, 500);
		check({device_enabled_ff, led_sink_outputs_oe_n_ff}, 8'h40);
		check({bank_enable_and_range, global_current_level}, 8'h00);
		$display("enable test done");
		u_host.write(1, 9, 1'b0);
		check(bank_enable_and_range, 8'h07);
		u_host.write(2, 1, 1'b1);
		check(global_current_level, 8'h0F);
		u_host.write(3, 2, 1'b0);
		check(bank_a_current_level, 8'h0E);
		u_host.write(3, 0, 1'b0);
		check(bank_a_current_level, 8'h00);
		u_host.write(4, 3, 1'b0);
		check(bank_b_current_level, 8'h0D);
		u_host.write(5, 15, 1'b0);
		check(bank_c_current_level, 8'h01);
		u_host.write(7, 13, 1'b0);
		check({bank_b_current_level, bank_c_current_level}, 8'hD1);
		$display("register test done");
		u_host.write(6, 1, 1'b0);
		check(unity_return_lock_bit, 8'h01);
		regulation_low <= 1'b1;
		wait_mode(2'h1);
		wait_mode(2'h2);
		wait_mode(2'h3);
		regulation_low <= 1'b0;
		unity_sufficient <= 1'b1;
		repeat (10) @(posedge sys_clk);
		check(pump_mode, 8'h03);
		unity_sufficient <= 1'b0;
		u_host.write(6, 2, 1'b0);
		check({unity_return_lock_bit, pump_mode}, 8'h00);
		regulation_low <= 1'b1;
		wait_mode(2'h1);
		regulation_low <= 1'b0;
		unity_sufficient <= 1'b1;
		repeat (2) @(posedge sys_clk);
		check(pump_mode, 8'h00);
		unity_sufficient <= 1'b0;
		$display("pump test done");
		u_host.level(1'b0, 220);
		check({bank_enable_and_range, global_current_level}, 8'h00);
		check(device_enabled_ff, 8'h01);
		u_host.level(1'b0, 60);
		check({device_enabled_ff, led_sink_outputs_oe_n_ff}, 8'h3F);
		u_host.level(1'b1, 500);
		check({device_enabled_ff, global_current_level}, 8'h10);
		u_host.write(2, 1, 1'b0);
		check(global_current_level, 8'h0F);
		undervoltage <= 1'b1;
		repeat (6) @(posedge sys_clk);
		check({device_enabled_ff, global_current_level}, 8'h00);
		check(led_sink_outputs_oe_n_ff, 8'h3F);
		$display("power test done");
		report_and_stop();
	end
endmodule

/* File: rtl/led_prog_ctrl.v */
// Program-line decoder, register file and power control of the LED driver
`include "led_ctl_defines.vh"
module led_prog_ctrl #(
	parameter [16:0] OFF_CYC = `OFF_CYC,
	parameter [16:0] DATA_TMO_CYC = `DATA_TMO_CYC,
	parameter [16:0] IDLE_CYC = `IDLE_CYC,
	parameter [16:0] PWRDN_CYC = `PWRDN_CYC,
	parameter [16:0] QUAL_CYC = `QUAL_CYC,
	parameter [7:0] GLITCH_CYC = `GLITCH_CYC
) (
	input wire sys_clk,
	input wire rst_n,
	input wire prog_line,
	input wire undervoltage,
	input wire regulation_low,
	input wire unity_sufficient,
	output reg device_enabled_ff,
	output wire current_range_select,
	output wire bank_a_on,
	output wire bank_b_on,
	output wire bank_c_on,
	output wire [3:0] global_current_level,
	output wire [3:0] bank_a_current_level,
	output wire [3:0] bank_b_current_level,
	output wire [3:0] bank_c_current_level,
	output wire unity_return_lock_bit,
	output wire [1:0] pump_mode,
	output reg [5:0] led_sink_outputs_oe_n_ff
);
	localparam [2:0] ST_OFF = 3'h0;
	localparam [2:0] ST_ADDR_WAIT = 3'h1;
	localparam [2:0] ST_ADDR_CNT = 3'h2;
	localparam [2:0] ST_DATA_WAIT = 3'h3;
	localparam [2:0] ST_DATA_CNT = 3'h4;

	// Pulse count to four-bit value: sixteen minus N, modulo sixteen
	function [3:0] pulse_to_level;
		input [4:0] pulses;
		reg [4:0] neg;
		begin
			neg = 5'h00 - pulses;
			pulse_to_level = neg[3:0]; // RULE23
		end
	endfunction

	// True when the pulse count names one of the six registers
	function addr_valid;
		input [4:0] pulses;
		begin
			addr_valid = (pulses >= `ADDR_FIRST) && (pulses <= `ADDR_LOCK);
		end
	endfunction

	// Falling-edge count, held at its ceiling so it never wraps
	function [4:0] count_fall;
		input [4:0] pulses;
		begin
			if (pulses == 5'h1F) begin
				count_fall = pulses;
			end else begin
				count_fall = pulses + 5'h01;
			end
		end
	endfunction

	wire line;
	reg line_q_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [4:0] pulse_cnt_ff;
	reg [4:0] nxt_pulse_cnt;
	reg [4:0] addr_ff;
	reg [4:0] nxt_addr;
	reg [16:0] since_edge_ff;
	reg [16:0] low_cnt_ff;
	reg [16:0] pwrdn_cnt_ff;
	reg uv_q_ff;
	reg uv_ff;
	reg [3:0] level_ff [0:4];
	reg lock_ff;
	reg sel_clear;
	reg commit;
	reg pump_reset;
	reg pwrdn_active_ff;

	wire fall = line_q_ff && !line;
	wire rise = !line_q_ff && line;
	wire any_edge = fall || rise;
	wire off_seen = !line && (low_cnt_ff == OFF_CYC - 17'h0_0001);
	wire idle_seen = line && (since_edge_ff == IDLE_CYC - 17'h0_0001);
	// Data timeout runs from the last address edge
	wire tmo_seen = since_edge_ff >= DATA_TMO_CYC - 17'h0_0001;
	// Shutdown only from a running state; the power-up low is not one
	wire shut_now = off_seen && state_ff != ST_OFF;
	wire clear_all = uv_ff || shut_now;
	wire [3:0] data_level = pulse_to_level(pulse_cnt_ff);
	// Lock takes one only for exactly one data pulse
	wire lock_value = pulse_cnt_ff == 5'h01;
	// Sinks release a fixed time after shutdown is seen
	wire pwrdn_done = pwrdn_active_ff && (pwrdn_cnt_ff == PWRDN_CYC - 17'h0_0001);
	// Leaving the off state waits for a power-down in flight
	wire wake = (state_ff == ST_OFF) && line && !pwrdn_active_ff;
	wire [5:0] clear_hit;
	wire [5:0] commit_hit;

	pulse_width_filter #(
		.MIN_CYC(GLITCH_CYC)
	) u_filter (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.line_raw(prog_line),
		.line_clean_ff(line)
	);

	pump_mode_sequencer #(
		.QUAL_CYC(QUAL_CYC)
	) u_pump (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pump_run(device_enabled_ff),
		.force_unity(pump_reset),
		.regulation_low(regulation_low),
		.unity_sufficient(unity_sufficient),
		.return_lock(lock_ff),
		.pump_mode_ff(pump_mode)
	);

	// Undervoltage flag is a level from another domain
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			uv_q_ff <= 1'b0;
			uv_ff <= 1'b0;
		end else begin
			uv_q_ff <= undervoltage;
			uv_ff <= uv_q_ff;
		end
	end

	// Previous filtered level for edge detection
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_q_ff <= 1'b0;
		end else begin
			line_q_ff <= line;
		end
	end

	// Cycles since the last edge, saturating
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			since_edge_ff <= 17'h0_0000;
		end else if (any_edge) begin
			since_edge_ff <= 17'h0_0000;
		end else if (since_edge_ff != 17'h1_FFFF) begin
			since_edge_ff <= since_edge_ff + 17'h0_0001;
		end
	end

	// Length of the current low level, saturating at the shutdown limit
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_ff <= 17'h0_0000;
		end else if (line) begin
			low_cnt_ff <= 17'h0_0000;
		end else if (low_cnt_ff != OFF_CYC - 17'h0_0001) begin
			low_cnt_ff <= low_cnt_ff + 17'h0_0001; // RULE7
		end
	end

	// Protocol state machine
	always @* begin
		nxt_state = state_ff;
		nxt_pulse_cnt = pulse_cnt_ff;
		nxt_addr = addr_ff;
		sel_clear = 1'b0;
		commit = 1'b0;
		pump_reset = 1'b0;
		case (state_ff)
			ST_OFF: begin
				nxt_pulse_cnt = 5'h00;
				if (wake) begin
					nxt_state = ST_ADDR_WAIT; // RULE6
				end
			end
			ST_ADDR_WAIT: begin
				nxt_pulse_cnt = 5'h00;
				if (fall) begin
					nxt_pulse_cnt = 5'h01; // RULE11
					nxt_state = ST_ADDR_CNT;
				end
			end
			ST_ADDR_CNT: begin
				if (fall) begin
					nxt_pulse_cnt = count_fall(pulse_cnt_ff); // RULE11
				end
				// Idle high closes the address phase
				if (idle_seen) begin
					nxt_pulse_cnt = 5'h00;
					if (addr_valid(pulse_cnt_ff)) begin
						nxt_addr = pulse_cnt_ff; // RULE11
						sel_clear = 1'b1; // RULE16
						pump_reset = pulse_cnt_ff == `ADDR_LOCK; // RULE26
						nxt_state = ST_DATA_WAIT;
					end else begin
						nxt_state = ST_ADDR_WAIT;
					end
				end
			end
			ST_DATA_WAIT: begin
				if (fall) begin
					nxt_pulse_cnt = 5'h01;
					nxt_state = ST_DATA_CNT;
				end else if (tmo_seen) begin
					nxt_state = ST_ADDR_WAIT; // RULE15
				end
			end
			ST_DATA_CNT: begin
				if (fall) begin
					nxt_pulse_cnt = count_fall(pulse_cnt_ff);
				end
				// Idle high commits the counted value
				if (idle_seen) begin
					commit = 1'b1; // RULE27
					nxt_pulse_cnt = 5'h00;
					nxt_state = ST_ADDR_WAIT; // RULE18
				end
			end
			default: begin
				nxt_pulse_cnt = 5'h00;
				nxt_state = ST_OFF;
			end
		endcase
		// Shutdown and undervoltage override any transfer in progress
		if (clear_all) begin
			nxt_state = ST_OFF; // RULE7
			nxt_pulse_cnt = 5'h00;
			sel_clear = 1'b0;
			commit = 1'b0;
		end
	end

	// Reset state waits for the line to rise, then looks for an address
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_OFF; // RULE19
			pulse_cnt_ff <= 5'h00;
			addr_ff <= 5'h00;
		end else begin
			state_ff <= nxt_state;
			pulse_cnt_ff <= nxt_pulse_cnt;
			addr_ff <= nxt_addr;
		end
	end

	// One-hot strobes for the register being cleared or written
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_hit
			assign clear_hit[gi] = sel_clear && nxt_addr == gi + 1; // RULE16
			assign commit_hit[gi] = commit && addr_ff == gi + 1; // RULE27
		end
	endgenerate

	// Four-bit registers: range and enables, global, bank A, B, C levels
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_level
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					level_ff[gi] <= `LEVEL_RESET;
				end else if (clear_all) begin
					level_ff[gi] <= `LEVEL_RESET; // RULE8
				end else if (clear_hit[gi]) begin
					level_ff[gi] <= `LEVEL_RESET; // RULE16
				end else if (commit_hit[gi]) begin
					level_ff[gi] <= data_level; // RULE10
				end
			end
		end
	endgenerate

	// Single-bit return lock register
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_ff <= `LOCK_RESET;
		end else if (clear_all) begin
			lock_ff <= `LOCK_RESET; // RULE21
		end else if (clear_hit[5]) begin
			lock_ff <= `LOCK_RESET; // RULE16
		end else if (commit_hit[5]) begin
			lock_ff <= lock_value; // RULE24
		end
	end

	// Power-down delay after shutdown is recognised
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwrdn_active_ff <= 1'b0;
			pwrdn_cnt_ff <= 17'h0_0000;
		end else if (uv_ff) begin
			pwrdn_active_ff <= 1'b0;
			pwrdn_cnt_ff <= 17'h0_0000;
		end else if (shut_now) begin
			pwrdn_active_ff <= 1'b1; // RULE21
			pwrdn_cnt_ff <= 17'h0_0000;
		end else if (pwrdn_done) begin
			pwrdn_active_ff <= 1'b0;
		end else if (pwrdn_active_ff) begin
			pwrdn_cnt_ff <= pwrdn_cnt_ff + 17'h0_0001;
		end
	end

	// Enable follows the line; drops on undervoltage or after power-down
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			device_enabled_ff <= 1'b0;
		end else if (uv_ff || pwrdn_done) begin
			device_enabled_ff <= 1'b0; // RULE8 RULE21
		end else if (wake) begin
			device_enabled_ff <= 1'b1; // RULE6
		end
	end

	// Sinks drive only while enabled, high impedance otherwise
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			led_sink_outputs_oe_n_ff <= 6'h3F;
		end else begin
			led_sink_outputs_oe_n_ff <= {6{!device_enabled_ff}}; // RULE9
		end
	end

	assign current_range_select = level_ff[0][`RANGE_BIT]; // RULE22
	assign bank_a_on = level_ff[0][`BANK_A_BIT]; // RULE22
	assign bank_b_on = level_ff[0][`BANK_B_BIT];
	assign bank_c_on = level_ff[0][`BANK_C_BIT];
	assign global_current_level = level_ff[1];
	assign bank_a_current_level = level_ff[2];
	assign bank_b_current_level = level_ff[3];
	assign bank_c_current_level = level_ff[4];
	assign unity_return_lock_bit = lock_ff;
endmodule

/* File: rtl/pulse_width_filter.v */
// Rejects program-line pulses shorter than the minimum width
`include "led_ctl_defines.vh"
module pulse_width_filter #(
	parameter [7:0] MIN_CYC = `GLITCH_CYC
) (
	input wire sys_clk,
	input wire rst_n,
	input wire line_raw,
	output reg line_clean_ff
);
	reg [7:0] stable_cnt_ff;
	wire differs = line_raw != line_clean_ff;

	// Output follows only after MIN_CYC cycles of a new level
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stable_cnt_ff <= 8'h00;
			line_clean_ff <= 1'b0;
		end else if (!differs) begin
			stable_cnt_ff <= 8'h00;
		end else if (stable_cnt_ff == MIN_CYC - 8'h01) begin // RULE13
			stable_cnt_ff <= 8'h00;
			line_clean_ff <= line_raw;
		end else begin
			stable_cnt_ff <= stable_cnt_ff + 8'h01;
		end
	end
endmodule

/* File: rtl/pump_mode_sequencer.v */
// Charge-pump ratio sequencer: steps up on demand, drops only to 1x
`include "led_ctl_defines.vh"
module pump_mode_sequencer #(
	parameter [16:0] QUAL_CYC = `QUAL_CYC
) (
	input wire sys_clk,
	input wire rst_n,
	input wire pump_run,
	input wire force_unity,
	input wire regulation_low,
	input wire unity_sufficient,
	input wire return_lock,
	output reg [1:0] pump_mode_ff
);
	reg [16:0] qual_cnt_ff;
	wire qual_done = qual_cnt_ff == QUAL_CYC - 17'h00001;
	wire go_unity = unity_sufficient && !return_lock; // RULE25

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pump_mode_ff <= `PUMP_1X; // RULE1
			qual_cnt_ff <= 17'h0_0000;
		end else if (!pump_run || force_unity) begin
			pump_mode_ff <= `PUMP_1X; // RULE26
			qual_cnt_ff <= 17'h0_0000;
		end else if (go_unity && pump_mode_ff != `PUMP_1X) begin
			pump_mode_ff <= `PUMP_1X; // RULE5
			qual_cnt_ff <= 17'h0_0000;
		end else if (!regulation_low || pump_mode_ff == `PUMP_2X) begin
			qual_cnt_ff <= 17'h0_0000; // RULE1
		end else if (qual_done) begin
			// RULE2 RULE3 RULE4
			pump_mode_ff <= pump_mode_ff + 2'h1;
			qual_cnt_ff <= 17'h0_0000;
		end else begin
			qual_cnt_ff <= qual_cnt_ff + 17'h0_0001;
		end
	end
endmodule

/* File: shared/led_ctl_defines.vh */
// Constants for the pulse-count LED driver control block
// Behaviour
// RULE1: Pump starts and stays in 1x when regulating
// RULE2: Unregulated 1x steps to 1.33x after delay
// RULE3: Unregulated 1.33x steps to 1.5x after delay
// RULE4: Unregulated 1.5x steps to 2x
// RULE5: Sufficient supply returns pump straight to 1x
// RULE6: First high from shutdown enables, currents zero
// RULE7: Line low over 1.5 ms means shutdown
// RULE8: Undervoltage disables channels and clears registers
// RULE9: Sinks high impedance while shut down
// RULE10: Five four-bit registers and one bit
// RULE11: Address falling edges one to six select register
// RULE12: Host pulse halves between 200 ns and 100 us
// RULE13: Pulses under 200 ns are ignored
// RULE14: Host waits 500-1000 us before data
// RULE15: No data within 1000 us discards phase
// RULE16: Addressing a register clears it to zero
// RULE17: Host waits 1.5 ms after data
// RULE18: Back to address wait within 2 ms
// RULE19: Power-up waits for address, 10 us setup
// RULE20: Host late at power-up waits 2 ms
// RULE21: Shutdown drops sinks about 1 ms later
// RULE22: Register one holds range and bank enables
// RULE23: Four-bit value is sixteen minus pulse count
// RULE24: One pulse sets lock, zero or two clear
// RULE25: Lock bit blocks automatic return to 1x
// RULE26: Addressing register six resets pump to 1x
// RULE27: Commit data after idle high, then re-arm
`ifndef LED_CTL_DEFINES_VH
`define LED_CTL_DEFINES_VH

`define CLK_NS 20
`define GLITCH_NS 200
`define GLITCH_CYC 8'h0A
`define QUAL_US 400
`define QUAL_CYC 17'h0_4E20
`define OFF_US 1500
`define OFF_CYC 17'h1_24F8
`define DATA_TMO_US 1000
`define DATA_TMO_CYC 17'h0_C350
`define IDLE_US 200
`define IDLE_CYC 17'h0_2710
`define PWRDN_US 1000
`define PWRDN_CYC 17'h0_C350
`define TIME_W 17

`define ADDR_FIRST 5'h01
`define ADDR_LAST_LEVEL 5'h05
`define ADDR_LOCK 5'h06
`define RANGE_BIT 3
`define BANK_A_BIT 2
`define BANK_B_BIT 1
`define BANK_C_BIT 0
`define LEVEL_RESET 4'h0
`define LOCK_RESET 1'b0

`define PUMP_1X 2'h0
`define PUMP_1P33X 2'h1
`define PUMP_1P5X 2'h2
`define PUMP_2X 2'h3

`endif
